//--- cms_cfg.svh
/*
  constants for the clock mode switch: register offsets, field positions,
  mode codes, reset values and oscillator stabilization counts.
  assumes inclusion by bare name from the design file and the bench.
*/
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH

// ----------------------------------------------------------------------
// register offsets (register port, 8-bit data)
// ----------------------------------------------------------------------
`define CMS_SYSCLK_CTRL_OFS  4'h0
`define CMS_OSC_CTRL_OFS     4'h1
`define CMS_PLL_CTRL_OFS     4'h2

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CMS_SEL_LSB          0
`define CMS_MON_LSB          4
`define CMS_MAIN_RC_EN_BIT   0
`define CMS_SUB_RC_EN_BIT    1
`define CMS_MAIN_OSC_EN_BIT  2
`define CMS_SUB_OSC_EN_BIT   3
`define CMS_MAIN_RC_RDY_BIT  4
`define CMS_SUB_RC_RDY_BIT   5
`define CMS_MAIN_OSC_RDY_BIT 6
`define CMS_SUB_OSC_RDY_BIT  7
`define CMS_PLL_EN_BIT       0
`define CMS_PLL_RDY_BIT      1

// ----------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------
`define CMS_CODE_SUB_OSC     3'h0
`define CMS_CODE_MAIN_OSC    3'h2
`define CMS_CODE_SUB_RC      3'h4
`define CMS_CODE_MAIN_RC     3'h6
`define CMS_CODE_MAIN_PLL    3'h7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CMS_RST_SEL          3'h6
`define CMS_RST_OSC_EN       4'h3

// ----------------------------------------------------------------------
// stabilization times in cycles of clk
// ----------------------------------------------------------------------
`define CMS_WAIT_W           16
`define CMS_MAIN_RC_WAIT     16'h0040
`define CMS_SUB_RC_WAIT      16'h0080
`define CMS_SUB_OSC_WAIT     16'h0100
`define CMS_MAIN_OSC_WAIT    16'h0100
`define CMS_PLL_WAIT         16'h0080

`endif

//--- cms_pkg.sv
/*
  types for the clock mode switch.
  assumes cms_cfg.svh is compiled alongside.
*/
`default_nettype none
package cms_pkg;
  typedef enum logic [1:0] {
    CMS_RESET_WAIT,
    CMS_RUN,
    CMS_SWITCH_WAIT
  } cms_state_e;
endpackage
`default_nettype wire

//--- cms_clock_mode_switch.sv
/*
  clock mode switch state machine: selects the machine clock mode,
  waits oscillator stabilization, keeps oscillator enables.
  assumes a plain register port on clk; stable flags are generated
  internally by counters once an oscillator is enabled.
*/
`default_nettype none
`include "cms_cfg.svh"

// Operation
// RL1 - five clock modes, chosen by software written select field
// RL2 - after reset wait both rc stabilizations, then enter main rc
// RL3 - from main rc or pll, sub rc code enters sub rc mode
// RL4 - sub rc disabled when selected: wait its stabilization first
// RL5 - sub rc enabled and stable: switch at once
// RL6 - subclock code: wait subclock stabilization, enter subclock mode
// RL7 - subclock enabled and stable: switch at once
// RL8 - main oscillator code: wait its stabilization, enter main mode
// RL9 - main oscillator enabled and stable: switch at once
// RL10 - from main mode, main rc code waits main rc stabilization
// RL11 - main rc enabled and stable: switch at once
// RL12 - from main mode, pll code waits pll stabilization
// RL13 - pll enabled and stable: switch at once (code also waits for main rc stable)
// RL14 - from main mode, sub codes behave as from main rc
// RL15 - active mode shown in monitor field; done when equals select
// RL16 - entering sub modes clears main enables; sets ignored there
module cms_clock_mode_switch (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // clock mode out
  output var  logic [2:0] clock_mode_monitor,
  output var  logic       switch_busy
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  cms_pkg::cms_state_e state_q;
  logic [2:0]  clock_mode_select_q;
  logic [2:0]  mon_q;
  logic [2:0]  target_q;
  logic        main_rc_osc_enable_q;
  logic        sub_rc_osc_enable_q;
  logic        main_osc_enable_q;
  logic        sub_osc_enable_q;
  logic        pll_enable_q;
  logic [`CMS_WAIT_W-1:0] cnt_q [5];
  logic [4:0]  stable;
  logic [4:0]  enables;
  logic        sub_family;
  logic        sel_wr;
  logic [2:0]  wr_sel;
  logic [2:0]  tgt_idx;
  logic        tgt_valid;
  logic        osc_wr;
  logic        pll_wr;
  logic        sel_take;
  logic        switch_done;
  logic        enter_sub;
  logic        enter_main_osc;
  logic        keep_main_rc;
  logic        keep_main_osc;
  logic        keep_sub_rc;
  logic        keep_sub_osc;
  logic        keep_pll;

  // reset enables, one bit per field position of the osc control register
  localparam logic [3:0] RST_EN = `CMS_RST_OSC_EN;

  // index of each oscillator: 0 main rc, 1 sub rc, 2 main osc, 3 sub, 4 pll
  function automatic logic [2:0] osc_idx(input logic [2:0] code);
    unique case (code)
      `CMS_CODE_MAIN_RC:  osc_idx = 3'h0;
      `CMS_CODE_SUB_RC:   osc_idx = 3'h1;
      `CMS_CODE_MAIN_OSC: osc_idx = 3'h2;
      `CMS_CODE_SUB_OSC:  osc_idx = 3'h3;
      default:            osc_idx = 3'h4;
    endcase
  endfunction

  // RL1 legal codes
  function automatic logic code_ok(input logic [2:0] code);
    code_ok = (code == `CMS_CODE_MAIN_RC) || (code == `CMS_CODE_SUB_RC) ||
              (code == `CMS_CODE_MAIN_OSC) || (code == `CMS_CODE_SUB_OSC) ||
              (code == `CMS_CODE_MAIN_PLL);
  endfunction

  function automatic logic [`CMS_WAIT_W-1:0] wait_of(input int i);
    unique case (i)
      0:       wait_of = `CMS_MAIN_RC_WAIT;
      1:       wait_of = `CMS_SUB_RC_WAIT;
      2:       wait_of = `CMS_MAIN_OSC_WAIT;
      3:       wait_of = `CMS_SUB_OSC_WAIT;
      default: wait_of = `CMS_PLL_WAIT;
    endcase
  endfunction

  assign sub_family = (mon_q == `CMS_CODE_SUB_RC) ||
                      (mon_q == `CMS_CODE_SUB_OSC);
  assign enables = {pll_enable_q, sub_osc_enable_q, main_osc_enable_q,
                    sub_rc_osc_enable_q, main_rc_osc_enable_q};
  assign sel_wr  = reg_wr && (reg_addr == `CMS_SYSCLK_CTRL_OFS);
  assign wr_sel  = reg_wdata[`CMS_SEL_LSB +: 3];
  assign tgt_idx = osc_idx(target_q);
  // pll runs from main rc, so it also needs main rc stable
  assign tgt_valid = (target_q == `CMS_CODE_MAIN_PLL) ?
                     (stable[4] && stable[0]) : stable[tgt_idx];

  // decoded writes and switch events shared by the enable registers
  assign osc_wr         = reg_wr && (reg_addr == `CMS_OSC_CTRL_OFS);
  assign pll_wr         = reg_wr && (reg_addr == `CMS_PLL_CTRL_OFS);
  assign sel_take       = sel_wr && code_ok(wr_sel);
  assign switch_done    = (state_q == cms_pkg::CMS_SWITCH_WAIT) && tgt_valid;
  assign enter_sub      = switch_done &&
                          ((target_q == `CMS_CODE_SUB_RC) ||
                           (target_q == `CMS_CODE_SUB_OSC));
  assign enter_main_osc = switch_done && (target_q == `CMS_CODE_MAIN_OSC);

  // a selected or active oscillator cannot be switched off by software
  assign keep_main_rc  = (clock_mode_select_q[2:1] == 2'h3) ||
                         (mon_q[2:1] == 2'h3);
  assign keep_main_osc = (clock_mode_select_q == `CMS_CODE_MAIN_OSC) ||
                         (mon_q == `CMS_CODE_MAIN_OSC);
  assign keep_sub_rc   = (clock_mode_select_q == `CMS_CODE_SUB_RC) ||
                         (mon_q == `CMS_CODE_SUB_RC);
  assign keep_sub_osc  = (clock_mode_select_q == `CMS_CODE_SUB_OSC) ||
                         (mon_q == `CMS_CODE_SUB_OSC);
  assign keep_pll      = (clock_mode_select_q == `CMS_CODE_MAIN_PLL) ||
                         (mon_q == `CMS_CODE_MAIN_PLL);

  // --------------------------------------------------------------------
  // stabilization counters
  // --------------------------------------------------------------------
  // RL4 counters restart whenever an oscillator is off
  for (genvar g = 0; g < 5; g++) begin : g_osc
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cnt_q[g] <= '0;
      end else if (!enables[g]) begin
        cnt_q[g] <= '0;
      end else if (cnt_q[g] != wait_of(g)) begin
        cnt_q[g] <= cnt_q[g] + 1'b1;
      end
    end
    assign stable[g] = enables[g] && (cnt_q[g] == wait_of(g));
  end

  // --------------------------------------------------------------------
  // select field
  // --------------------------------------------------------------------
  // RL1 software written select, illegal codes ignored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_mode_select_q <= `CMS_RST_SEL;
    end else if (sel_wr && code_ok(wr_sel)) begin
      clock_mode_select_q <= wr_sel;
    end
  end

  // --------------------------------------------------------------------
  // oscillator enables
  // --------------------------------------------------------------------
  // selecting a mode forces its oscillator on, and that set wins over an
  // automatic clear in the same cycle: a lost set would leave the next
  // switch waiting on an oscillator that never starts

  // RL10 main rc forced on by main rc or pll select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      main_rc_osc_enable_q <= RST_EN[`CMS_MAIN_RC_EN_BIT];
    end else if (sel_take && (wr_sel[2:1] == 2'h3)) begin
      main_rc_osc_enable_q <= 1'b1;
    end else if (enter_sub || enter_main_osc) begin
      // RL16 leaving the main rc family stops it
      main_rc_osc_enable_q <= 1'b0;
    end else if (osc_wr &&
                 (!sub_family || !reg_wdata[`CMS_MAIN_RC_EN_BIT])) begin
      main_rc_osc_enable_q <= reg_wdata[`CMS_MAIN_RC_EN_BIT] ||
                              keep_main_rc;
    end
  end

  // RL4 sub rc forced on by its select, never cleared automatically
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sub_rc_osc_enable_q <= RST_EN[`CMS_SUB_RC_EN_BIT];
    end else if (sel_take && (wr_sel == `CMS_CODE_SUB_RC)) begin
      sub_rc_osc_enable_q <= 1'b1;
    end else if (osc_wr) begin
      sub_rc_osc_enable_q <= reg_wdata[`CMS_SUB_RC_EN_BIT] ||
                             keep_sub_rc;
    end
  end

  // RL8 main oscillator forced on by its select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      main_osc_enable_q <= RST_EN[`CMS_MAIN_OSC_EN_BIT];
    end else if (sel_take && (wr_sel == `CMS_CODE_MAIN_OSC)) begin
      main_osc_enable_q <= 1'b1;
    end else if (enter_sub) begin
      // RL16 entering sub family clears main enables
      main_osc_enable_q <= 1'b0;
    end else if (osc_wr &&
                 (!sub_family || !reg_wdata[`CMS_MAIN_OSC_EN_BIT])) begin
      main_osc_enable_q <= reg_wdata[`CMS_MAIN_OSC_EN_BIT] ||
                           keep_main_osc;
    end
  end

  // RL6 subclock forced on by its select, never cleared automatically
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sub_osc_enable_q <= RST_EN[`CMS_SUB_OSC_EN_BIT];
    end else if (sel_take && (wr_sel == `CMS_CODE_SUB_OSC)) begin
      sub_osc_enable_q <= 1'b1;
    end else if (osc_wr) begin
      sub_osc_enable_q <= reg_wdata[`CMS_SUB_OSC_EN_BIT] ||
                          keep_sub_osc;
    end
  end

  // RL12 pll forced on by its select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_enable_q <= 1'b0;
    end else if (sel_take && (wr_sel == `CMS_CODE_MAIN_PLL)) begin
      pll_enable_q <= 1'b1;
    end else if (enter_sub || enter_main_osc) begin
      // RL16 sets of the pll enable are ignored in sub family
      pll_enable_q <= 1'b0;
    end else if (pll_wr &&
                 (!sub_family || !reg_wdata[`CMS_PLL_EN_BIT])) begin
      pll_enable_q <= reg_wdata[`CMS_PLL_EN_BIT] || keep_pll;
    end
  end

  // --------------------------------------------------------------------
  // mode state machine
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= cms_pkg::CMS_RESET_WAIT;
      mon_q    <= `CMS_RST_SEL;
      target_q <= `CMS_RST_SEL;
    end else begin
      unique case (state_q)
        // RL2 both rc oscillators must settle after reset
        cms_pkg::CMS_RESET_WAIT: begin
          if (stable[0] && stable[1]) state_q <= cms_pkg::CMS_RUN;
        end
        cms_pkg::CMS_RUN: begin
          // RL3 RL14 any legal new code starts a switch
          if (clock_mode_select_q != mon_q) begin
            target_q <= clock_mode_select_q;
            state_q  <= cms_pkg::CMS_SWITCH_WAIT;
          end
        end
        cms_pkg::CMS_SWITCH_WAIT: begin
          // RL5 RL7 RL9 RL11 RL13 stable target passes at once;
          // RL6 RL8 RL10 RL12 otherwise wait for the counter
          if (tgt_valid) begin
            mon_q   <= target_q;
            state_q <= cms_pkg::CMS_RUN;
          end
        end
        default: begin
          // the unused state code falls back to a fresh boot wait
          state_q <= cms_pkg::CMS_RESET_WAIT;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // outputs and read port
  // --------------------------------------------------------------------
  // RL15 monitor shows active mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_mode_monitor <= `CMS_RST_SEL;
    end else begin
      clock_mode_monitor <= mon_q;
    end
  end

  // busy covers the boot wait as well as every switch wait
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      switch_busy <= 1'b1;
    end else begin
      switch_busy <= (state_q != cms_pkg::CMS_RUN);
    end
  end

  // read data stand the cycle after the strobe only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        `CMS_SYSCLK_CTRL_OFS:
          reg_rdata <= {1'b0, mon_q, 1'b0, clock_mode_select_q};
        `CMS_OSC_CTRL_OFS:
          reg_rdata <= {stable[3], stable[2], stable[1], stable[0],
                        enables[3:0]};
        `CMS_PLL_CTRL_OFS:
          reg_rdata <= {6'h00, stable[4], pll_enable_q};
        default:
          reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- cms_monitor.sv
/*
  checker for the clock mode switch: port assertions, bound to the top.
  assumes the register map and mode codes of cms_cfg.svh.
*/
`default_nettype none
`include "cms_cfg.svh"
module cms_monitor (
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // clock mode out
  input wire logic [2:0] clock_mode_monitor,
  input wire logic       switch_busy
);
  logic [2:0] sel_q;
  logic [7:0] age_q;
  logic       legal;
  assign legal = reg_wdata[2:0] inside {`CMS_CODE_SUB_OSC, `CMS_CODE_MAIN_OSC,
    `CMS_CODE_SUB_RC, `CMS_CODE_MAIN_RC, `CMS_CODE_MAIN_PLL};
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------------
  // shadow select and reset age
  // ----------------------------------------------------------------------
  // illegal codes leave the shadow alone, so refusals are checked too
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      sel_q <= `CMS_RST_SEL;
    else if (reg_wr && reg_addr == `CMS_SYSCLK_CTRL_OFS && legal)
      sel_q <= reg_wdata[2:0];
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      age_q <= 8'h00;
    else if (age_q != 8'hFF)
      age_q <= age_q + 8'h01;
  end
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence sel_wr;
    reg_wr && reg_addr == `CMS_SYSCLK_CTRL_OFS && legal && !switch_busy;
  endsequence
  sequence mode_done;
    !switch_busy && clock_mode_monitor == sel_q;
  endsequence
  mode_legal_a: assert property (clock_mode_monitor inside {3'h0, 3'h2,
    3'h4, 3'h6, 3'h7}) else $error("monitor shows an unused code");
  reset_wait_a: assert property (age_q < 8'h80 |-> switch_busy
    && clock_mode_monitor == `CMS_CODE_MAIN_RC) else $error("early boot");
  reset_end_a: assert property (age_q == 8'h96 |-> !switch_busy
    && clock_mode_monitor == `CMS_CODE_MAIN_RC) else $error("boot late");
  switch_bound_a: assert property (sel_wr |-> ##[2:600] mode_done)
    else $error("mode switch did not finish");
  mon_step_a: assert property ($changed(clock_mode_monitor)
    |-> $past(switch_busy)) else $error("mode changed without a wait");
  done_match_a: assert property ($fell(switch_busy)
    |-> clock_mode_monitor == sel_q) else $error("wait ended off target");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  rd_sel_a: assert property ($past(reg_rd) && $past(reg_addr) == 4'h0
    |-> reg_rdata[2:0] == $past(sel_q)) else $error("select readback");
  rd_unmap_a: assert property ($past(reg_rd) && $past(reg_addr) > 4'h2
    |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  sub_clear_a: assert property ($past(reg_rd) && $past(reg_addr) == 4'h1
    && !$past(switch_busy) && $past(clock_mode_monitor) inside {3'h0, 3'h4}
    && $past(sel_q) inside {3'h0, 3'h4} |-> reg_rdata[2] == 1'b0
    && reg_rdata[0] == 1'b0) else $error("main enables set in sub mode");
endmodule
bind cms_clock_mode_switch cms_monitor cms_monitor_i (.clk(clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .clock_mode_monitor(clock_mode_monitor), .switch_busy(switch_busy));
`default_nettype wire

//--- cms_clock_mode_switch_tb_top.sv
/*
  bench for the clock mode switch: walks the mode transitions.
  assumes the stabilization counts and reset enables of the design.
*/
`default_nettype none
`include "cms_cfg.svh"
module cms_clock_mode_switch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, resetn, reg_wr, reg_rd, switch_busy;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [2:0] clock_mode_monitor;
  int         n_errors, n_checks;
  cms_clock_mode_switch cms_clock_mode_switch_i (.clk(clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clock_mode_monitor(clock_mode_monitor), .switch_busy(switch_busy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // a cold start waits at least the shortest stabilization count
  function automatic bit lat_ok(input bit cold, input int n);
    return cold ? (n >= 60 && n < 700) : (n <= 6);
  endfunction
  task automatic step(input logic [2:0] c, input bit cold);
    int n;
    n = 0;
    wr(`CMS_SYSCLK_CTRL_OFS, {5'h00, c});
    #1;
    while (!(switch_busy === 1'b0 && clock_mode_monitor === c) && n < 700) begin
      @(posedge clk);
      #1 n++;
    end
    chk("mode", {5'h00, c}, {5'h00, clock_mode_monitor});
    chk("latency", 8'h01, {7'h00, lat_ok(cold, n)});
    rd(`CMS_SYSCLK_CTRL_OFS, d);
    chk("sysclk", {1'b0, c, 1'b0, c}, d);
  endtask
  task automatic boot();
    int n;
    n = 0;
    while (switch_busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    chk("boot_wait", 8'h01, {7'h00, n >= 120});
    chk("boot_mode", 8'h06, {5'h00, clock_mode_monitor});
    repeat (30) @(posedge clk);
  endtask
  task automatic osc_on();
    wr(`CMS_OSC_CTRL_OFS, 8'h0F);
    wr(`CMS_PLL_CTRL_OFS, 8'h01);
    repeat (300) @(posedge clk);
  endtask
  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    #300us;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = 15'h0000;
    n_errors = 0;
    n_checks = 0;
    void'($urandom(20887));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    boot();
    rd(`CMS_SYSCLK_CTRL_OFS, d);
    chk("sysclk", 8'h66, d);
    rd(`CMS_OSC_CTRL_OFS, d);
    chk("osc", 8'h33, d);
    for (int i = 0; i < 4; i++) begin
      wr(`CMS_SYSCLK_CTRL_OFS, {5'h00, 3'h1 + 3'(2 * ($urandom % 3))});
      rd(4'h3 + 4'($urandom % 13), d);
      chk("unmapped", 8'h00, d);
      rd(`CMS_SYSCLK_CTRL_OFS, d);
      chk("refused", 8'h66, d);
    end
    step(`CMS_CODE_SUB_RC, 1'b0);
    wr(`CMS_OSC_CTRL_OFS, 8'h0F);
    wr(`CMS_PLL_CTRL_OFS, 8'h01);
    rd(`CMS_OSC_CTRL_OFS, d);
    chk("osc_sub", 8'h2A, d);
    rd(`CMS_PLL_CTRL_OFS, d);
    chk("pll_sub", 8'h00, d);
    step(`CMS_CODE_MAIN_RC, 1'b1);
    step(`CMS_CODE_MAIN_OSC, 1'b1);
    step(`CMS_CODE_MAIN_RC, 1'b1);
    osc_on();
    step(`CMS_CODE_MAIN_OSC, 1'b0);
    osc_on();
    step(`CMS_CODE_MAIN_PLL, 1'b0);
    step(`CMS_CODE_SUB_OSC, 1'b0);
    step(`CMS_CODE_MAIN_OSC, 1'b1);
    step(`CMS_CODE_MAIN_PLL, 1'b1);
    step(`CMS_CODE_SUB_RC, 1'b0);
    step(`CMS_CODE_MAIN_OSC, 1'b1);
    step(`CMS_CODE_SUB_RC, 1'b0);
    step(`CMS_CODE_MAIN_OSC, 1'b1);
    osc_on();
    step(`CMS_CODE_MAIN_RC, 1'b0);
    wr(`CMS_SYSCLK_CTRL_OFS, 8'h02);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("rst_busy", 8'h01, {7'h00, switch_busy});
    chk("rst_mode", 8'h06, {5'h00, clock_mode_monitor});
    @(posedge clk);
    resetn <= 1'b1;
    boot();
    wr(`CMS_OSC_CTRL_OFS, 8'h01);
    step(`CMS_CODE_SUB_RC, 1'b1);
    step(`CMS_CODE_SUB_OSC, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
